// [hw/dmxr_map.svh]
`ifndef DMXR_MAP_SVH
`define DMXR_MAP_SVH
// register byte offsets
`define DMXR_OFS_SLOT_A     12'h000
`define DMXR_OFS_SLOT_B     12'h004
`define DMXR_OFS_STATUS     12'h008
`define DMXR_OFS_POSITION   12'h00c
`define DMXR_OFS_LIMITS     12'h010
// reset values
`define DMXR_RST_SLOT       32'h0000_0000
`define DMXR_RST_POS        16'h0000
// status field positions
`define DMXR_ST_LED_LSB     0
`define DMXR_ST_CW_SET      2
`define DMXR_ST_CCW_SET     3
`define DMXR_ST_ANG_KNOWN   4
`define DMXR_ST_MOVING      5
`define DMXR_ST_DIR         6
`define DMXR_ST_ANGULAR     7
// mode channel thresholds on an 8-bit slot (80 %, 50 % and 55 %)
`define DMXR_MODE_ANG_MIN   8'hcc
`define DMXR_SAVE_MIN       8'h80
`define DMXR_SAVE_MAX       8'h8c
// approach deceleration: rate = distance >> shift
`define DMXR_DECEL_SHIFT    4
// timing
`define DMXR_CLK_KHZ        200000
`define DMXR_FAST_HALF_MS   125
`define DMXR_SLOW_HALF_MS   500
`endif

// [hw/dmxr_pkg.sv]
`default_nettype none
package dmxr_pkg;
  typedef enum logic [1:0] {
    DMXR_LED_FAST,
    DMXR_LED_SLOW,
    DMXR_LED_STEADY
  } dmxr_led_t;

  typedef enum logic [1:0] {
    DMXR_ST_IDLE,
    DMXR_ST_MANUAL,
    DMXR_ST_SEEK
  } dmxr_state_t;
endpackage : dmxr_pkg
`default_nettype wire

// [hw/dmxr_step_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// phase accumulator: one step pulse per carry, so step rate tracks rate
module dmxr_step_gen #(
  parameter int ACC_W = 16
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] rate,
  output logic            step
);
  logic [ACC_W-1:0] acc;
  logic [ACC_W:0]   next_acc;

  assign next_acc = {1'b0, acc} + {{(ACC_W-7){1'b0}}, rate};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc  <= '0;
      step <= 1'b0;
    end
    else
    begin
      acc  <= next_acc[ACC_W-1:0];
      step <= next_acc[ACC_W];
    end
  end
endmodule : dmxr_step_gen
`default_nettype wire

// [hw/dmxr_led_flash.sv]
`timescale 1ns/1ps
`default_nettype none
module dmxr_led_flash
  import dmxr_pkg::*;
#(
  parameter int FAST_HALF_CYC = 25000000,
  parameter int SLOW_HALF_CYC = 100000000
) (
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire dmxr_led_t mode,
  output logic           led
);
  logic [31:0] cnt;
  logic [31:0] half;

  assign half = (mode == DMXR_LED_FAST) ? 32'(FAST_HALF_CYC) :
                32'(SLOW_HALF_CYC);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 32'h0000_0000;
      led <= 1'b0;
    end
    else if (mode == DMXR_LED_STEADY)
    begin
      cnt <= 32'h0000_0000;
      led <= 1'b1;
    end
    else if (cnt >= half - 32'h0000_0001)
    begin
      cnt <= 32'h0000_0000;
      led <= ~led;
    end
    else
    begin
      cnt <= cnt + 32'h0000_0001;
    end
  end
endmodule : dmxr_led_flash
`default_nettype wire

// [hw/dmxr_rotator_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmxr_map.svh"
module dmxr_rotator_ctrl
  import dmxr_pkg::*;
#(
  parameter int FAST_HALF_CYC = `DMXR_FAST_HALF_MS * `DMXR_CLK_KHZ,
  parameter int SLOW_HALF_CYC = `DMXR_SLOW_HALF_MS * `DMXR_CLK_KHZ,
  parameter int ACC_W         = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        index_pin,
  output logic             motor_step,
  output logic             motor_dir,
  output logic             status_led
);
  logic [31:0] slot_a;
  logic [31:0] slot_b;
  logic [15:0] pos;
  logic [15:0] next_pos;
  logic [15:0] cw_limit;
  logic [15:0] ccw_limit;
  logic [15:0] index_ofs;
  logic        cw_set;
  logic        ccw_set;
  logic        angle_known;
  logic        prev_cw;
  logic        prev_ccw;
  logic        ang_dir;
  logic        idx_s1;
  logic        idx_s2;
  logic        idx_s3;
  dmxr_state_t state;
  dmxr_state_t next_state;
  dmxr_led_t   led_mode;

  logic [7:0]  ch_coarse;
  logic [7:0]  ch_fine;
  logic [7:0]  ch_speed;
  logic [7:0]  ch_cw;
  logic [7:0]  ch_ccw;
  logic [7:0]  ch_mode;
  logic [15:0] target16;
  logic        angular;
  logic        save_win;
  logic        taught;
  logic        ready;
  logic        cw_act;
  logic        ccw_act;
  logic [15:0] angle;
  logic [15:0] ang_diff;
  logic [15:0] span;
  logic [16:0] t17;
  logic [32:0] scaled;
  logic [15:0] lim_target;
  logic        seek_dir;
  logic [15:0] seek_dist;
  logic        at_target;
  logic [15:0] dec_raw;
  logic [7:0]  dec_rate;
  logic [7:0]  seek_rate;
  logic [7:0]  run_rate;
  logic        run_dir;
  logic        step_pulse;
  logic        acc_en;
  logic        setup;
  logic        mapped;
  logic [31:0] rd_word;

  // slot decode
  assign ch_coarse = slot_a[7:0];
  assign ch_fine   = slot_a[15:8];
  assign ch_speed  = slot_a[23:16];
  assign ch_cw     = slot_a[31:24];
  assign ch_ccw    = slot_b[7:0];
  assign ch_mode   = slot_b[15:8];

  assign target16 = {ch_coarse, ch_fine};
  assign angular  = (ch_mode >= `DMXR_MODE_ANG_MIN);
  assign save_win = (ch_mode >= `DMXR_SAVE_MIN) &&
                    (ch_mode <= `DMXR_SAVE_MAX);
  assign taught   = cw_set & ccw_set;
  assign ready    = angular ? angle_known : taught;
  // clockwise has priority when both manual slots are raised
  assign cw_act   = (ch_cw != 8'h00);
  assign ccw_act  = (ch_ccw != 8'h00);

  // one revolution is the full 16-bit step count
  assign angle    = pos - index_ofs;
  assign ang_diff = target16 - angle;

  // full scale reaches the clockwise limit exactly
  assign span       = cw_limit - ccw_limit;
  assign t17        = {1'b0, target16} + {16'h0000, target16[15]};
  assign scaled     = 33'(t17) * 33'(span);
  assign lim_target = ccw_limit + scaled[31:16];

  always_comb
  begin
    if (angular)
    begin
      seek_dir  = ang_dir;
      seek_dist = ang_dir ? ang_diff : 16'h0000 - ang_diff;
    end
    else if (lim_target > pos)
    begin
      seek_dir  = 1'b1;
      seek_dist = lim_target - pos;
    end
    else
    begin
      seek_dir  = 1'b0;
      seek_dist = pos - lim_target;
    end
  end

  assign at_target = (seek_dist == 16'h0000);

  // slow down near target, never below one
  assign dec_raw  = seek_dist >> `DMXR_DECEL_SHIFT;
  assign dec_rate = (dec_raw > 16'h00ff) ? 8'hff :
                    (dec_raw == 16'h0000) ? 8'h01 : dec_raw[7:0];
  assign seek_rate = (dec_rate < ch_speed) ? dec_rate : ch_speed;

  always_comb
  begin
    next_state = DMXR_ST_IDLE;
    if (cw_act || ccw_act)
      next_state = DMXR_ST_MANUAL;
    else if (ready && !at_target)
      next_state = DMXR_ST_SEEK;
  end

  always_comb
  begin
    run_rate = 8'h00;
    run_dir  = motor_dir;
    unique case (state)
      DMXR_ST_IDLE:
      begin
        run_rate = 8'h00;
      end
      DMXR_ST_MANUAL:
      begin
        run_rate = cw_act ? ch_cw : ch_ccw;
        run_dir  = cw_act;
      end
      DMXR_ST_SEEK:
      begin
        run_rate = seek_rate;
        run_dir  = seek_dir;
      end
    endcase
    if (ch_speed == 8'h00)
      run_rate = 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= DMXR_ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ang_dir <= 1'b1;
    else if (next_state == DMXR_ST_SEEK && state == DMXR_ST_MANUAL)
      // carry on the manual direction
      // manual slots already read zero here, so keep the running direction
      ang_dir <= motor_dir;
    else if (next_state == DMXR_ST_SEEK && state == DMXR_ST_IDLE)
      ang_dir <= ~ang_diff[15];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      motor_dir <= 1'b1;
    else
      motor_dir <= run_dir;
  end

  dmxr_step_gen #(
    .ACC_W (ACC_W)
  ) u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .rate    (run_rate),
    .step    (step_pulse)
  );

  assign motor_step = step_pulse;

  // the pulse and motor_dir come from the same edge, so they pair
  assign next_pos = !step_pulse ? pos :
                    motor_dir ? pos + 16'h0001 : pos - 16'h0001;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos <= `DMXR_RST_POS;
    else
      pos <= next_pos;
  end

  // index sensor sync; only idx_s2 and idx_s3 feed the edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_s1 <= 1'b0;
      idx_s2 <= 1'b0;
      idx_s3 <= 1'b0;
    end
    else
    begin
      idx_s1 <= index_pin;
      idx_s2 <= idx_s1;
      idx_s3 <= idx_s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      index_ofs   <= `DMXR_RST_POS;
      angle_known <= 1'b0;
    end
    else if (idx_s2 && !idx_s3)
    begin
      index_ofs   <= pos;
      angle_known <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_cw  <= 1'b0;
      prev_ccw <= 1'b0;
    end
    else
    begin
      prev_cw  <= cw_act;
      prev_ccw <= ccw_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cw_limit <= `DMXR_RST_POS;
      cw_set   <= 1'b0;
    end
    else if (prev_cw && !cw_act && save_win && !angular)
    begin
      // a step already launched still lands: store where the shaft stops
      cw_limit <= next_pos;
      cw_set   <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ccw_limit <= `DMXR_RST_POS;
      ccw_set   <= 1'b0;
    end
    else if (prev_ccw && !ccw_act && save_win && !angular)
    begin
      ccw_limit <= next_pos;
      ccw_set   <= 1'b1;
    end
  end

  always_comb
  begin
    if (!ready)
      led_mode = DMXR_LED_FAST;
    else if (state != DMXR_ST_IDLE)
      led_mode = DMXR_LED_SLOW;
    else
      led_mode = DMXR_LED_STEADY;
  end

  dmxr_led_flash #(
    .FAST_HALF_CYC (FAST_HALF_CYC),
    .SLOW_HALF_CYC (SLOW_HALF_CYC)
  ) u_led (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (led_mode),
    .led     (status_led)
  );

  // apb slave: zero wait states, read data latched in the setup phase
  assign setup  = psel && !penable;
  assign acc_en = psel && penable;
  assign mapped = (paddr == `DMXR_OFS_SLOT_A) ||
                  (paddr == `DMXR_OFS_SLOT_B) ||
                  (paddr == `DMXR_OFS_STATUS) ||
                  (paddr == `DMXR_OFS_POSITION) ||
                  (paddr == `DMXR_OFS_LIMITS);
  assign pready  = 1'b1;
  assign pslverr = acc_en && !mapped;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `DMXR_OFS_SLOT_A:   rd_word = slot_a;
      `DMXR_OFS_SLOT_B:   rd_word = slot_b;
      `DMXR_OFS_STATUS:
      begin
        rd_word[`DMXR_ST_LED_LSB +: 2] = led_mode;
        rd_word[`DMXR_ST_CW_SET]       = cw_set;
        rd_word[`DMXR_ST_CCW_SET]      = ccw_set;
        rd_word[`DMXR_ST_ANG_KNOWN]    = angle_known;
        rd_word[`DMXR_ST_MOVING]       = (state != DMXR_ST_IDLE);
        rd_word[`DMXR_ST_DIR]          = motor_dir;
        rd_word[`DMXR_ST_ANGULAR]      = angular;
      end
      `DMXR_OFS_POSITION: rd_word = {angle, pos};
      `DMXR_OFS_LIMITS:   rd_word = {cw_limit, ccw_limit};
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_word;
  end

  // byte lanes map one-to-one onto slots; slot_b takes lanes 0 and 1 only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_a <= `DMXR_RST_SLOT;
      slot_b <= `DMXR_RST_SLOT;
    end
    else if (acc_en && pwrite)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (pstrb[i] && paddr == `DMXR_OFS_SLOT_A)
          slot_a[8*i +: 8] <= pwdata[8*i +: 8];
        if (pstrb[i] && i < 2 && paddr == `DMXR_OFS_SLOT_B)
          slot_b[8*i +: 8] <= pwdata[8*i +: 8];
      end
    end
  end

  AST_BRAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (ch_speed == 8'h00) [*2] |=> !motor_step)
    else $error("step issued with speed slot at zero");

  AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
    (state == DMXR_ST_SEEK) |-> $past(ready))
    else $error("positioning move started while not ready");

  AST_SLOW_LED: assert property (@(posedge pclk)
    disable iff (!presetn)
    (ready && state == DMXR_ST_SEEK) |-> led_mode == DMXR_LED_SLOW)
    else $error("no slow flash while travelling");

  AST_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
    (ready && state == DMXR_ST_IDLE) [*3] |-> status_led)
    else $error("indicator not steady at target");

  AST_CW_STORE: assert property (@(posedge pclk)
    disable iff (!presetn)
    (prev_cw && !cw_act && save_win && !angular)
      |=> cw_set && cw_limit == $past(next_pos))
    else $error("clockwise limit not stored");

  AST_NO_STORE: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!save_win) |=> $stable(cw_limit) && $stable(ccw_limit))
    else $error("limit stored outside save window");

  AST_CW_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (state == DMXR_ST_MANUAL && cw_act) |=> motor_dir)
    else $error("manual clockwise run turned the wrong way");

  AST_CCW_RUN: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state == DMXR_ST_MANUAL && !cw_act && ccw_act) |=> !motor_dir)
    else $error("manual counter-clockwise run turned the wrong way");

  AST_CAP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == DMXR_ST_SEEK) |-> run_rate <= ch_speed && run_rate != 8'h00
      || ch_speed == 8'h00)
    else $error("seek rate above speed slot or stalled");

  AST_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
    (state == DMXR_ST_IDLE && next_state == DMXR_ST_SEEK && angular)
      |=> ang_dir == !$past(ang_diff[15]))
    else $error("angular move not on shorter path");

  AST_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == DMXR_ST_MANUAL && next_state == DMXR_ST_SEEK && angular)
      |=> ang_dir == $past(motor_dir) ##1 $stable(ang_dir))
    else $error("direction reversed after manual run");
endmodule : dmxr_rotator_ctrl
`default_nettype wire

// [dv/dmxr_console.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmxr_map.svh"
// console stand-in: slot values reach the block as apb byte-lane writes
module dmxr_console (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, input logic [3:0] strb,
                      output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    // no latency assumed: hold until ready is sampled high
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines carry the inverse, so stale values never match
    paddr   <= ~addr;
    pwdata  <= ~wdata;
    pstrb   <= ~strb;
  endtask : xfer

  // every lane carries the byte, so a write that ignored its strobe
  // would clobber the neighbouring slots
  task automatic set_slot(input int idx, input logic [7:0] val);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, (idx < 4) ? `DMXR_OFS_SLOT_A : `DMXR_OFS_SLOT_B,
         {4{val}}, 4'h1 << (idx % 4), rd, er);
  endtask : set_slot

  // both position bytes go in one write so no half target is seen;
  // the unstrobed upper lanes carry junk that must not land
  task automatic set_pos(input logic [15:0] t);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, `DMXR_OFS_SLOT_A, {~t, t[7:0], t[15:8]}, 4'h3, rd, er);
  endtask : set_pos
endmodule : dmxr_console
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmxr_map.svh"
module tb;
  import dmxr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        index_pin;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        motor_step;
  logic        motor_dir;
  logic        status_led;
  logic [31:0] rd;
  logic        er;
  logic [15:0] cw;
  logic [15:0] ccw;
  int          err_count;
  int          tests_run;
  int          steps;
  int          tog;

  // short flash periods and a narrow accumulator keep the run brief
  dmxr_rotator_ctrl #(.FAST_HALF_CYC(8), .SLOW_HALF_CYC(32), .ACC_W(8))
    u_dmxr_rotator_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .index_pin(index_pin), .motor_step(motor_step),
    .motor_dir(motor_dir), .status_led(status_led));

  dmxr_console u_dmxr_console (.pclk(pclk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  always #2.5 pclk = ~pclk;

  always @(posedge pclk)
    if (motor_step === 1'b1)
      steps <= steps + 1;

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic rdr(input logic [11:0] a);
    u_dmxr_console.xfer(1'b0, a, 32'h0000_0000, 4'h0, rd, er);
  endtask : rdr

  task automatic slot(input int i, input logic [7:0] v);
    u_dmxr_console.set_slot(i, v);
  endtask : slot

  task automatic count_tog(input int n);
    logic prev;
    prev = status_led;
    tog  = 0;
    repeat (n)
    begin
      @(posedge pclk);
      if (status_led !== prev)
        tog++;
      prev = status_led;
    end
  endtask : count_tog

  task automatic poll_idle();
    int n;
    n = 0;
    do
    begin
      cyc(64);
      rdr(`DMXR_OFS_STATUS);
      n++;
    end
    while (rd[5] !== 1'b0 && n < 400);
    chk("seek_done", rd[5], 1'b0);
  endtask : poll_idle

  task automatic t_reset();
    int s0;
    slot(2, 8'hff);
    u_dmxr_console.set_pos(16'hffff);
    s0 = steps;
    cyc(300);
    chk("refused_steps", steps - s0, 0);
    rdr(`DMXR_OFS_STATUS);
    chk("mapped_ok", er, 1'b0);
    chk("led_unset", rd[1:0], DMXR_LED_FAST);
    chk("limits_unset", rd[3:2], 2'b00);
    count_tog(64);
    chk("fast_flash", tog >= 7 && tog <= 9, 1'b1);
    rdr(12'hffc);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0000_0000);
    u_dmxr_console.set_pos(16'h0000);
  endtask : t_reset

  task automatic t_teach();
    int s0;
    int c;
    logic [15:0] p0;
    slot(5, 8'h8d);
    rdr(`DMXR_OFS_SLOT_B);
    chk("slot_b_lanes", rd, 32'h0000_8d00);
    slot(3, 8'hff);
    cyc(40);
    slot(3, 8'h00);
    cyc(4);
    rdr(`DMXR_OFS_STATUS);
    chk("outside_window", rd[2], 1'b0);
    slot(2, 8'h00);
    slot(3, 8'hff);
    cyc(10);
    s0 = steps;
    cyc(100);
    chk("brake", steps - s0, 0);
    slot(3, 8'h00);
    slot(2, 8'hff);
    slot(5, 8'h80);
    rdr(`DMXR_OFS_POSITION);
    p0 = rd[15:0];
    s0 = steps;
    slot(3, 8'h40);
    cyc(8);
    c = steps;
    cyc(512);
    chk("rate_40", steps - c >= 127 && steps - c <= 129, 1'b1);
    chk("cw_dir", motor_dir, 1'b1);
    slot(3, 8'h80);
    cyc(8);
    c = steps;
    cyc(512);
    chk("rate_80", steps - c >= 255 && steps - c <= 257, 1'b1);
    slot(3, 8'h00);
    cyc(4);
    rdr(`DMXR_OFS_STATUS);
    chk("cw_stored", rd[2], 1'b1);
    rdr(`DMXR_OFS_POSITION);
    cw = rd[15:0];
    chk("cw_travel", cw - p0, 16'(steps - s0));
    rdr(`DMXR_OFS_LIMITS);
    chk("cw_limit", rd[31:16], cw);
    slot(4, 8'hff);
    cyc(8);
    chk("ccw_dir", motor_dir, 1'b0);
    cyc(200);
    slot(4, 8'h00);
    cyc(4);
    rdr(`DMXR_OFS_POSITION);
    ccw = rd[15:0];
    chk("ccw_below", ccw < cw, 1'b1);
    rdr(`DMXR_OFS_LIMITS);
    chk("ccw_limit", rd[15:0], ccw);
    rdr(`DMXR_OFS_STATUS);
    chk("led_ready", rd[1:0], DMXR_LED_STEADY);
  endtask : t_teach

  task automatic t_seek();
    int s0;
    logic [31:0] span;
    logic [15:0] exp;
    count_tog(40);
    chk("steady_pin", {tog == 0, status_led}, 2'b11);
    span = 32'(cw - ccw);
    exp  = ccw + 16'((32'h4080 * span) >> 16);
    slot(2, 8'h01);
    slot(5, 8'h00);
    u_dmxr_console.set_pos(16'h4080);
    cyc(16);
    rdr(`DMXR_OFS_STATUS);
    chk("moving", rd[5], 1'b1);
    chk("led_slow", rd[1:0], DMXR_LED_SLOW);
    chk("seek_dir", motor_dir, 1'b1);
    s0 = steps;
    count_tog(512);
    chk("slow_speed_cap", steps - s0 <= 3, 1'b1);
    chk("slow_flash", tog >= 15 && tog <= 17, 1'b1);
    slot(2, 8'hff);
    s0 = steps;
    cyc(512);
    chk("fast_speed", steps - s0 >= 4, 1'b1);
    poll_idle();
    chk("led_done", rd[1:0], DMXR_LED_STEADY);
    rdr(`DMXR_OFS_POSITION);
    chk("seek_pos", rd[15:0], exp);
  endtask : t_seek

  task automatic t_angle();
    slot(5, 8'hcb);
    rdr(`DMXR_OFS_STATUS);
    chk("mode_cb", rd[7], 1'b0);
    slot(5, 8'hcc);
    rdr(`DMXR_OFS_STATUS);
    chk("mode_cc", rd[7], 1'b1);
    chk("led_no_zero", rd[1:0], DMXR_LED_FAST);
    u_dmxr_console.set_pos(16'h0000);
    // one rising and one falling edge on the index sensor
    repeat (2)
    begin
      index_pin <= ~index_pin;
      cyc(4);
    end
    rdr(`DMXR_OFS_POSITION);
    chk("angle_zero", rd[31:16], 16'h0000);
    u_dmxr_console.set_pos(16'hfff0);
    cyc(8);
    chk("short_way", motor_dir, 1'b0);
    poll_idle();
    rdr(`DMXR_OFS_POSITION);
    chk("angle_pos", rd[31:16], 16'hfff0);
    slot(3, 8'hff);
    cyc(100);
    slot(3, 8'h00);
    cyc(8);
    chk("keep_dir", motor_dir, 1'b1);
    cyc(256);
    rdr(`DMXR_OFS_STATUS);
    chk("keep_going", rd[6:5], 2'b11);
  endtask : t_angle

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (100000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    index_pin = 1'b0;
    err_count = 0;
    tests_run = 0;
    steps     = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_teach();
    t_seek();
    t_angle();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
